// ### hdl/pafs_pkg.sv
package pafs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] AF_EN_A_OFS     = 8'h00;
  localparam logic [7:0] AF_EN_B_OFS     = 8'h04;
  localparam logic [7:0] SEL_LOW_B_OFS   = 8'h08;
  localparam logic [7:0] SEL_HIGH_B_OFS  = 8'h0C;
  localparam logic [7:0] AF_EN_C_OFS     = 8'h10;
  localparam logic [7:0] SEL_LOW_C_OFS   = 8'h14;
  localparam logic [7:0] SEL_HIGH_C_OFS  = 8'h18;
  localparam logic [7:0] ROUTE_B_OFS     = 8'h1C;
  localparam logic [7:0] ROUTE_C_OFS     = 8'h20;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // port b pin positions
  localparam int unsigned PB_CLK_PIN     = 3;
  localparam int unsigned PB_VREF_PIN    = 5;
  localparam int unsigned PB_CHAN7_PIN   = 4;
  // port a pins that own a function: pa0, pa1, pa6, pa7
  localparam logic [7:0] PA_FUNC_MASK    = 8'hC3;
  // port b pins with a function under select bit 1: pins 0..5
  localparam logic [7:0] PB_SEL1_MASK    = 8'h3F;
  // port b pins with a function under select bit 0: only pin 3
  localparam logic [7:0] PB_SEL0_MASK    = 8'h08;
  // port c pins covered here: 0 and 1, function under select bit 1
  localparam logic [7:0] PC_SEL1_MASK    = 8'h03;
endpackage : pafs_pkg

// ### hdl/pafs_route.sv
`timescale 1ns/1ns
// per-port pin routing: which pins hand over to a peripheral
module pafs_route (
  input  wire logic [7:0] af_enable,
  input  wire logic [7:0] sel_low,
  input  wire logic [7:0] sel1_mask,
  input  wire logic [7:0] sel0_mask,
  output logic      [7:0] route_sel1,
  output logic      [7:0] route_sel0
);
  // a pin routes only when enabled and the select picks a real function
  always_comb
  begin
    route_sel1 = af_enable & sel_low & sel1_mask;
    route_sel0 = af_enable & ~sel_low & sel0_mask;
  end
endmodule : pafs_route

// ### hdl/pafs_top.sv
`timescale 1ns/1ns
// How it works
// - port a has no function-set registers; one function per pin
// - port a enable alone connects that pin's single peripheral function
// - port b high select register exists, read/write, but selects nothing
// - port c high select register exists, read/write, but selects nothing
// - ports b and c route only when enabled and the select bit picks a real function
// - portb_pin3: select 0 gives external clock, 1 gives adc channel 3
// - port b pins 0,1,2,4 give adc channels 0,1,2,7 on select 1
// - portb_pin5 gives adc reference input on select 1
// - port c pins 0,1 give adc/comparator positive and negative inputs
// - routed pins take direction from the peripheral, not the port
module pafs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // per-pin direction requests from the peripherals
  input  wire logic [7:0]  periph_oe_a,
  input  wire logic [7:0]  periph_oe_b,
  input  wire logic [7:0]  periph_oe_c,
  // port data direction from the ordinary gpio logic (1 = output)
  input  wire logic [7:0]  gpio_oe_a,
  input  wire logic [7:0]  gpio_oe_b,
  input  wire logic [7:0]  gpio_oe_c,
  output logic [7:0]       pin_oe_a,
  output logic [7:0]       pin_oe_b,
  output logic [7:0]       pin_oe_c,
  output logic [7:0]       periph_owns_a,
  output logic [7:0]       periph_owns_b,
  output logic [7:0]       periph_owns_c,
  output logic             ext_clock_input,
  output logic             adc_chan_0,
  output logic             adc_chan_1,
  output logic             adc_chan_2,
  output logic             adc_chan_3,
  output logic             adc_chan_7,
  output logic             adc_vref_in,
  output logic             adc4_or_cmp_pos,
  output logic             adc5_or_cmp_neg
);
  logic [7:0]  af_en_a_q;
  logic [7:0]  af_en_b_q;
  logic [7:0]  sel_low_b_q;
  logic [7:0]  sel_high_b_q;
  logic [7:0]  af_en_c_q;
  logic [7:0]  sel_low_c_q;
  logic [7:0]  sel_high_c_q;
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [7:0]  w_data_q;
  logic        w_strb0_q;
  logic        arpend_q;
  logic [7:0]  b_route1;
  logic [7:0]  b_route0;
  logic [7:0]  c_route1;
  logic [7:0]  c_route0_unused;
  logic [7:0]  own_a_d;
  logic [7:0]  own_b_d;
  logic [7:0]  own_c_d;
  logic        do_write;

  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      pafs_pkg::AF_EN_A_OFS, pafs_pkg::AF_EN_B_OFS,
      pafs_pkg::SEL_LOW_B_OFS, pafs_pkg::SEL_HIGH_B_OFS,
      pafs_pkg::AF_EN_C_OFS, pafs_pkg::SEL_LOW_C_OFS,
      pafs_pkg::SEL_HIGH_C_OFS, pafs_pkg::ROUTE_B_OFS,
      pafs_pkg::ROUTE_C_OFS: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // write address and data are caught separately, in either order
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign do_write      = aw_held_q & w_held_q;
  assign s_axi_arready = ~arpend_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb0_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_axi_wdata[7:0];
      w_strb0_q <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pafs_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_addr_q) ? pafs_pkg::RESP_OKAY
                                            : pafs_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // only byte lane 0 carries register data; status words ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      af_en_a_q    <= pafs_pkg::REG_RESET;
      af_en_b_q    <= pafs_pkg::REG_RESET;
      sel_low_b_q  <= pafs_pkg::REG_RESET;
      sel_high_b_q <= pafs_pkg::REG_RESET;
      af_en_c_q    <= pafs_pkg::REG_RESET;
      sel_low_c_q  <= pafs_pkg::REG_RESET;
      sel_high_c_q <= pafs_pkg::REG_RESET;
    end
    else if (do_write && w_strb0_q)
    begin
      case (aw_addr_q)
        pafs_pkg::AF_EN_A_OFS:    af_en_a_q    <= w_data_q;
        pafs_pkg::AF_EN_B_OFS:    af_en_b_q    <= w_data_q;
        pafs_pkg::SEL_LOW_B_OFS:  sel_low_b_q  <= w_data_q;
        pafs_pkg::SEL_HIGH_B_OFS: sel_high_b_q <= w_data_q;
        pafs_pkg::AF_EN_C_OFS:    af_en_c_q    <= w_data_q;
        pafs_pkg::SEL_LOW_C_OFS:  sel_low_c_q  <= w_data_q;
        pafs_pkg::SEL_HIGH_C_OFS: sel_high_c_q <= w_data_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arpend_q     <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pafs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      arpend_q     <= 1'b1;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_known(s_axi_araddr) ? pafs_pkg::RESP_OKAY
                                               : pafs_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        pafs_pkg::AF_EN_A_OFS:    s_axi_rdata <= {24'h000000, af_en_a_q};
        pafs_pkg::AF_EN_B_OFS:    s_axi_rdata <= {24'h000000, af_en_b_q};
        pafs_pkg::SEL_LOW_B_OFS:  s_axi_rdata <= {24'h000000, sel_low_b_q};
        pafs_pkg::SEL_HIGH_B_OFS: s_axi_rdata <= {24'h000000, sel_high_b_q};
        pafs_pkg::AF_EN_C_OFS:    s_axi_rdata <= {24'h000000, af_en_c_q};
        pafs_pkg::SEL_LOW_C_OFS:  s_axi_rdata <= {24'h000000, sel_low_c_q};
        pafs_pkg::SEL_HIGH_C_OFS: s_axi_rdata <= {24'h000000, sel_high_c_q};
        pafs_pkg::ROUTE_B_OFS:    s_axi_rdata <= {24'h000000, periph_owns_b};
        pafs_pkg::ROUTE_C_OFS:    s_axi_rdata <= {24'h000000, periph_owns_c};
        default:                  s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      arpend_q     <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
  end

  // high select registers are deliberately not wired into the routing
  pafs_route u_route_b (
    .af_enable  (af_en_b_q),
    .sel_low    (sel_low_b_q),
    .sel1_mask  (pafs_pkg::PB_SEL1_MASK),
    .sel0_mask  (pafs_pkg::PB_SEL0_MASK),
    .route_sel1 (b_route1),
    .route_sel0 (b_route0)
  );

  pafs_route u_route_c (
    .af_enable  (af_en_c_q),
    .sel_low    (sel_low_c_q),
    .sel1_mask  (pafs_pkg::PC_SEL1_MASK),
    .sel0_mask  (8'h00),
    .route_sel1 (c_route1),
    .route_sel0 (c_route0_unused)
  );

  assign own_a_d = af_en_a_q & pafs_pkg::PA_FUNC_MASK;
  assign own_b_d = b_route1 | b_route0;
  assign own_c_d = c_route1 | c_route0_unused;

  // route state registered so outputs come from flip-flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      periph_owns_a   <= 8'h00;
      periph_owns_b   <= 8'h00;
      periph_owns_c   <= 8'h00;
      ext_clock_input <= 1'b0;
      adc_chan_0      <= 1'b0;
      adc_chan_1      <= 1'b0;
      adc_chan_2      <= 1'b0;
      adc_chan_3      <= 1'b0;
      adc_chan_7      <= 1'b0;
      adc_vref_in     <= 1'b0;
      adc4_or_cmp_pos <= 1'b0;
      adc5_or_cmp_neg <= 1'b0;
    end
    else
    begin
      periph_owns_a   <= own_a_d;
      periph_owns_b   <= own_b_d;
      periph_owns_c   <= own_c_d;
      ext_clock_input <= b_route0[pafs_pkg::PB_CLK_PIN];
      adc_chan_3      <= b_route1[pafs_pkg::PB_CLK_PIN];
      adc_chan_0      <= b_route1[0];
      adc_chan_1      <= b_route1[1];
      adc_chan_2      <= b_route1[2];
      adc_chan_7      <= b_route1[pafs_pkg::PB_CHAN7_PIN];
      adc_vref_in     <= b_route1[pafs_pkg::PB_VREF_PIN];
      adc4_or_cmp_pos <= c_route1[0];
      adc5_or_cmp_neg <= c_route1[1];
    end
  end

  // per pin: owning peripheral decides direction, else the port register
  assign pin_oe_a = (periph_owns_a & periph_oe_a)
                  | (~periph_owns_a & gpio_oe_a);
  assign pin_oe_b = (periph_owns_b & periph_oe_b)
                  | (~periph_owns_b & gpio_oe_b);
  assign pin_oe_c = (periph_owns_c & periph_oe_c)
                  | (~periph_owns_c & gpio_oe_c);
endmodule : pafs_top

// ### dv/pafs_periph_model.sv
`timescale 1ns/1ns
// peripheral side: direction requests move every cycle so a stuck mux shows
module pafs_periph_model (
  input  wire logic       aclk,
  output logic      [7:0] periph_oe_a,
  output logic      [7:0] periph_oe_b,
  output logic      [7:0] periph_oe_c
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge aclk)
    cnt_q <= cnt_q + 8'h01;
  // each peripheral steers its own pin direction once routed
  assign periph_oe_a = cnt_q ^ 8'h5A;
  assign periph_oe_b = {cnt_q[3:0], cnt_q[7:4]};
  assign periph_oe_c = ~cnt_q;
endmodule : pafs_periph_model

// ### dv/pafs_top_sva.sv
`timescale 1ns/1ns
module pafs_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  periph_oe_b,
  input wire logic [7:0]  gpio_oe_b,
  input wire logic [7:0]  pin_oe_b,
  input wire logic [7:0]  periph_owns_a,
  input wire logic [7:0]  periph_owns_b,
  input wire logic [7:0]  periph_owns_c,
  input wire logic        ext_clock_input,
  input wire logic        adc_chan_3,
  input wire logic        adc_chan_7,
  input wire logic        adc_vref_in,
  input wire logic        adc5_or_cmp_neg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_route_steady: assert property (!s_axi_bvalid [*2] |->
    $stable(periph_owns_b)) else $error("routing moved without write");
  a_pin_dir_b: assert property (
    pin_oe_b == ((periph_owns_b & periph_oe_b) |
    (~periph_owns_b & gpio_oe_b))) else $error("pin direction wrong");
  a_port_a_mask: assert property (
    (periph_owns_a & ~pafs_pkg::PA_FUNC_MASK) == 8'h00) else $error("pa");
  a_pin67_free: assert property (
    periph_owns_b[7:6] == 2'h0) else $error("pb6/pb7 routed");
  a_clk_pin: assert property (periph_owns_b[3] == (ext_clock_input ^
    adc_chan_3) && !(ext_clock_input && adc_chan_3))
    else $error("portb_pin3 routing wrong");
  a_chan7_pin: assert property (
    adc_chan_7 == periph_owns_b[4]) else $error("chan7 wrong");
  a_vref_pin: assert property (
    adc_vref_in == periph_owns_b[5]) else $error("vref wrong");
  a_cmp_neg: assert property (
    adc5_or_cmp_neg == periph_owns_c[1]) else $error("cmp neg wrong");
endmodule : pafs_top_sva
bind pafs_top pafs_top_sva u_sva (.*);

// ### dv/port_alt_function_select_test.sv
`timescale 1ns/1ns
module port_alt_function_select_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_clock_input;
  logic        adc_chan_0, adc_chan_1, adc_chan_2, adc_chan_3, adc_chan_7;
  logic        adc_vref_in, adc4_or_cmp_pos, adc5_or_cmp_neg;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, periph_oe_a, periph_oe_b;
  logic [7:0]  periph_oe_c, gpio_oe_a, gpio_oe_b, gpio_oe_c, pin_oe_a;
  logic [7:0]  pin_oe_b, pin_oe_c, periph_owns_a, periph_owns_b, e;
  logic [7:0]  periph_owns_c, regs [7];
  logic [7:0]  ea, ec;
  logic        lazy;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          errors, samples_checked, cycles, k;
  pafs_top DUT (.*);
  pafs_periph_model u_periph (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] route_b(input logic [7:0] en,
                                         input logic [7:0] sel);
    return en & ((sel & pafs_pkg::PB_SEL1_MASK) |
                 (~sel & pafs_pkg::PB_SEL0_MASK));
  endfunction : route_b
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  always @(posedge aclk)
  begin
    cycles++;
    if (!aresetn)
    begin
      gpio_oe_a <= 8'h00;
      gpio_oe_b <= 8'h00;
      gpio_oe_c <= 8'h00;
    end
    else
    begin
      gpio_oe_a <= gpio_oe_a + 8'h35;
      gpio_oe_b <= gpio_oe_a ^ 8'hC3;
      gpio_oe_c <= ~gpio_oe_b;
    end
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb, tv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !lazy;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      tv = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      else if (tv) s_axi_bready <= 1'b1;
    end
  endtask : wr
  task rd(input logic [7:0] a);
    logic ta, tr, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !lazy;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      tv = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      else if (tv) s_axi_rready <= 1'b1;
    end
  endtask : rd
  // expectations come from the shadow copy, never from the design
  task check_all;
    @(negedge aclk);
    e = route_b(regs[1], regs[2]);
    ea = regs[0] & pafs_pkg::PA_FUNC_MASK;
    ec = regs[4] & regs[5] & pafs_pkg::PC_SEL1_MASK;
    chk(periph_owns_a, ea);
    chk(periph_owns_b, e);
    chk(periph_owns_c, ec);
    chk({ext_clock_input, adc_chan_0, adc_chan_1, adc_chan_2, adc_chan_3,
         adc_chan_7, adc_vref_in}, {regs[1][3] & ~regs[2][3],
         e[0], e[1], e[2], e[3] & regs[2][3], e[4], e[5]});
    chk({adc4_or_cmp_pos, adc5_or_cmp_neg},
        {regs[4][0] & regs[5][0], regs[4][1] & regs[5][1]});
    chk(pin_oe_a, (ea & periph_oe_a) | (~ea & gpio_oe_a));
    chk(pin_oe_b, (e & periph_oe_b) | (~e & gpio_oe_b));
    chk(pin_oe_c, (ec & periph_oe_c) | (~ec & gpio_oe_c));
  endtask : check_all
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    lazy = 1'b0;
    seed = 32'h55;
    for (k = 0; k < 7; k++) regs[k] = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    $display("test reset done");
    // portb_pin3 both settings, pb6/pb7 never routed
    wr(8'h04, 32'h00FF);
    wr(8'h08, 32'h0000);
    regs[1] = 8'hFF;
    check_all();
    wr(8'h08, 32'h00FF);
    regs[2] = 8'hFF;
    check_all();
    $display("test corners done");
    for (k = 0; k < 60; k++)
    begin
      d = rnd();
      s_axi_wstrb <= d[3:0];
      // a late ready makes the response wait, exercising the hold checks
      lazy = d[4];
      wr(8'(d[10:8] % 3'h7) << 2, rnd());
      chk(resp, pafs_pkg::RESP_OKAY);
      if (d[0]) regs[d[10:8] % 3'h7] = s_axi_wdata[7:0];
      check_all();
      rd(8'(d[10:8] % 3'h7) << 2);
      chk(rdat, {24'h0, regs[d[10:8] % 3'h7]});
      chk(resp, pafs_pkg::RESP_OKAY);
    end
    $display("test random done");
    lazy = 1'b0;
    s_axi_wstrb <= 4'hF;
    wr(8'h24, 32'h00FF);
    chk(resp, pafs_pkg::RESP_SLVERR);
    rd(8'h24);
    chk(rdat, 32'h0);
    chk(resp, pafs_pkg::RESP_SLVERR);
    wr(pafs_pkg::ROUTE_B_OFS, 32'h00FF);
    chk(resp, pafs_pkg::RESP_OKAY);
    check_all();
    rd(pafs_pkg::ROUTE_B_OFS);
    chk(rdat, {24'h0, route_b(regs[1], regs[2])});
    rd(pafs_pkg::ROUTE_C_OFS);
    chk(rdat, {24'h0, regs[4] & regs[5] & pafs_pkg::PC_SEL1_MASK});
    $display("test refusals done");
    // mid-run reset must clear every register and hand all pins back
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 7; k++) regs[k] = 8'h00;
    check_all();
    rd(pafs_pkg::SEL_LOW_B_OFS);
    chk(rdat, 32'h0);
    $display("test reset again done");
    stop_test();
  end
endmodule : port_alt_function_select_test
